// >>> hdl/plr_pkg.sv
// Shared constants for the loop lock and reset control block.
package plr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] PLR_REG_CTRL = 8'h00;
  localparam logic [7:0] PLR_REG_STATUS = 8'h04;
  localparam logic [7:0] PLR_REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] PLR_REG_IRQ_EN = 8'h0C;
  localparam logic [7:0] PLR_REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] PLR_REG_OSC_WORD = 8'h14;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int PLR_CTRL_AUTO_BIT = 0;
  localparam int PLR_CTRL_SWRST_BIT = 1;
  localparam int PLR_CTRL_MODE_LSB = 4;
  localparam int PLR_MODE_W = 3;

  // Feedback mode codes.
  localparam logic [2:0] PLR_MODE_SRC_SYNC = 3'h0;
  localparam logic [2:0] PLR_MODE_NO_COMP = 3'h1;
  localparam logic [2:0] PLR_MODE_NORMAL = 3'h2;
  localparam logic [2:0] PLR_MODE_ZERO_DELAY = 3'h3;
  localparam logic [2:0] PLR_MODE_EXT_FB = 3'h4;
  localparam logic [2:0] PLR_MODE_LVDS = 3'h5;
  localparam logic [2:0] PLR_MODE_RST = 3'h2;

  // ==========================================================================
  // Status and interrupt fields
  // ==========================================================================
  localparam int PLR_ST_LOCKED_BIT = 0;
  localparam int PLR_ST_IN_RST_BIT = 1;
  localparam int PLR_ST_PFD_BIT = 2;
  localparam int PLR_ST_FREQ_BIT = 3;
  localparam int PLR_ST_PHASE_BIT = 4;

  localparam int PLR_IRQ_W = 4;
  localparam int PLR_IRQ_LOCK_BIT = 0;
  localparam int PLR_IRQ_UNLOCK_BIT = 1;
  localparam int PLR_IRQ_AUTORST_BIT = 2;
  localparam int PLR_IRQ_MODE_ERR_BIT = 3;
  localparam logic [3:0] PLR_IRQ_EN_RST = 4'h0;

  // ==========================================================================
  // Loop model constants
  // ==========================================================================
  localparam int PLR_CNT_W = 16;
  localparam logic [15:0] PLR_OSC_NOMINAL = 16'h0008;
  localparam logic [15:0] PLR_PH_TOL = 16'h0001;
  localparam logic [3:0] PLR_LOCK_GOOD = 4'h8;
  localparam logic [15:0] PLR_NET_COMP_CYC = 16'h0002;
  localparam logic [15:0] PLR_SRC_COMP_CYC = 16'h0001;

  // Self reset pulse length, time in ns and derived cycle count (rounded up).
  localparam int PLR_CLK_PERIOD_NS = 40;
  localparam int PLR_AUTO_RST_NS = 1000;
  localparam logic [7:0] PLR_AUTO_RST_CYC =
    8'((PLR_AUTO_RST_NS + PLR_CLK_PERIOD_NS - 1) / PLR_CLK_PERIOD_NS);

endpackage

// >>> hdl/plr_sync.sv
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/10ps
module plr_sync
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous level in, synchronised level out.
  input wire logic d_i,
  output logic q_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } plr_sync_state_t;

  plr_sync_state_t st_r;
  plr_sync_state_t st_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = d_i;
    st_nxt.sync = st_r.meta;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.sync;

endmodule

// >>> hdl/plr_ctrl.sv
// Loop lock detection, detector gating, loop reset and APB register control.
//
// Function
// RULE_01: Detector disabled holds oscillator word, loop runs.
// RULE_02: Core may drive detector enable from switchover flags.
// RULE_03: Loop reset clears counters, outputs, lock, word; the code loads the word with PLR_OSC_NOMINAL instead.
// RULE_04: After reset release, loop resyncs and relocks.
// RULE_05: Core pulses loop reset after every lock loss; the core model pulses only when the bench raises pulse_i.
// RULE_06: Optional self reset after loss of lock.
// RULE_07: Design drives loop reset when switchover used.
// RULE_08: Core resets loop once input clock stable.
// RULE_09: Lock only on phase and frequency match.
// RULE_10: Six modes; lvds only on side loops.
// RULE_11: No high bandwidth with external feedback.
// RULE_12: Side external feedback needs single-ended, one standard.
// RULE_13: External feedback drives multiply output to port.
// RULE_14: Normal mode compensates clock network delay.
// RULE_15: No-compensation mode applies no delay compensation.
// RULE_16: Lvds mode inverts clock by 180 degrees.
// RULE_17: Zero delay mode uses single-ended bidirectional feedback.
// RULE_18: Core holds downstream reset until lock.
`timescale 1ns/10ps
module plr_ctrl
  import plr_pkg::*;
#(
  parameter bit SIDE_LOC = 1'b1
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core control.
  input wire logic loop_reset_i,
  input wire logic pfd_enable_i,
  output logic locked_o,
  output logic irq_o,
  // Clock pins.
  input wire logic ref_clk_i,
  input wire logic feedback_in_i,
  output logic external_clock_output_o,
  output logic feedback_out_port_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [2:0] mode;
    logic auto_en;
    logic sw_rst;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [15:0] osc_word;
    logic [15:0] osc_cnt;
    logic osc_clk;
    logic ext_clk;
    logic fb_out;
    logic [15:0] ref_cnt;
    logic [15:0] fb_cnt;
    logic [15:0] ref_per;
    logic [15:0] fb_per;
    logic ref_q;
    logic fb_q;
    logic [3:0] good_cnt;
    logic locked;
    logic freq_ok;
    logic phase_ok;
    logic [7:0] arst_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } plr_state_t;

  plr_state_t st_r;
  plr_state_t st_nxt;

  logic ref_sync;
  logic fb_sync;
  logic rst_sync;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  plr_sync u_sync_ref
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(ref_clk_i),
    .q_o(ref_sync)
  );

  plr_sync u_sync_fb
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(feedback_in_i),
    .q_o(fb_sync)
  );

  plr_sync u_sync_rst
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(loop_reset_i),
    .q_o(rst_sync)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Bus decode, loop model, lock detection and interrupt status.
  always_comb
  begin
    logic loop_rst, ext_path, fb_src, ref_edge, fb_edge, f_ok, p_ok;
    logic [3:0] ev, clr;
    logic [15:0] off, ph, fdiff;
    logic [2:0] new_mode;
    loop_rst = 1'b0;
    ext_path = 1'b0;
    fb_src = 1'b0;
    ref_edge = 1'b0;
    fb_edge = 1'b0;
    ev = '0;
    clr = '0;
    off = '0;
    ph = '0;
    fdiff = '0;
    f_ok = 1'b0;
    p_ok = 1'b0;
    new_mode = '0;
    st_nxt = st_r;

    // Any of the three reset sources holds the loop in reset.
    loop_rst = rst_sync | st_r.sw_rst | (st_r.arst_cnt != 8'h00);
    // Zero delay and external feedback close the loop through the pin.
    ext_path = (st_r.mode == PLR_MODE_EXT_FB) || (st_r.mode == PLR_MODE_ZERO_DELAY);
    fb_src = ext_path ? fb_sync : st_r.osc_clk;
    ref_edge = ref_sync & ~st_r.ref_q;
    fb_edge = fb_src & ~st_r.fb_q;
    st_nxt.ref_q = ref_sync;
    st_nxt.fb_q = fb_src;

    // Expected feedback lag per mode.
    if (st_r.mode == PLR_MODE_NORMAL)
      off = PLR_NET_COMP_CYC; // [RULE_14]
    else if ((st_r.mode == PLR_MODE_SRC_SYNC) || (st_r.mode == PLR_MODE_LVDS))
      off = PLR_SRC_COMP_CYC;
    else
      off = 16'h0000; // [RULE_15]

    // APB: one wait state, data and error prepared in the first access cycle.
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel_i && penable_i && !st_r.pready)
    begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      if (paddr_i == PLR_REG_CTRL)
      begin
        st_nxt.prdata[PLR_CTRL_AUTO_BIT] = st_r.auto_en;
        st_nxt.prdata[PLR_CTRL_SWRST_BIT] = st_r.sw_rst;
        st_nxt.prdata[PLR_CTRL_MODE_LSB +: PLR_MODE_W] = st_r.mode;
      end
      else if (paddr_i == PLR_REG_STATUS)
      begin
        st_nxt.prdata[PLR_ST_LOCKED_BIT] = st_r.locked;
        st_nxt.prdata[PLR_ST_IN_RST_BIT] = loop_rst;
        st_nxt.prdata[PLR_ST_PFD_BIT] = pfd_enable_i;
        st_nxt.prdata[PLR_ST_FREQ_BIT] = st_r.freq_ok;
        st_nxt.prdata[PLR_ST_PHASE_BIT] = st_r.phase_ok;
      end
      else if (paddr_i == PLR_REG_IRQ_STAT)
        st_nxt.prdata[PLR_IRQ_W-1:0] = st_r.irq_stat;
      else if (paddr_i == PLR_REG_IRQ_EN)
        st_nxt.prdata[PLR_IRQ_W-1:0] = st_r.irq_en;
      else if (paddr_i == PLR_REG_IRQ_CLR)
        st_nxt.prdata = 32'h0000_0000;
      else if (paddr_i == PLR_REG_OSC_WORD)
        st_nxt.prdata[PLR_CNT_W-1:0] = st_r.osc_word;
      else
        st_nxt.pslverr = 1'b1;
      // Writes return zero data.
      if (pwrite_i)
        st_nxt.prdata = 32'h0000_0000;
    end

    // Writes take effect at the completing edge of the access.
    if (psel_i && penable_i && st_r.pready && pwrite_i && !st_r.pslverr)
    begin
      if (paddr_i == PLR_REG_CTRL)
      begin
        st_nxt.auto_en = pwdata_i[PLR_CTRL_AUTO_BIT];
        st_nxt.sw_rst = pwdata_i[PLR_CTRL_SWRST_BIT];
        new_mode = pwdata_i[PLR_CTRL_MODE_LSB +: PLR_MODE_W];
        // Unused codes, and lvds on a top or bottom loop, are refused; the old mode stays.
        if ((new_mode > PLR_MODE_LVDS) || ((new_mode == PLR_MODE_LVDS) && !SIDE_LOC))
          ev[PLR_IRQ_MODE_ERR_BIT] = 1'b1; // [RULE_10]
        else
          st_nxt.mode = new_mode; // [RULE_10]
      end
      else if (paddr_i == PLR_REG_IRQ_EN)
        st_nxt.irq_en = pwdata_i[PLR_IRQ_W-1:0];
      else if (paddr_i == PLR_REG_IRQ_CLR)
        clr = pwdata_i[PLR_IRQ_W-1:0];
    end

    if (loop_rst)
    begin
      // Counters, outputs and lock cleared, oscillator back to nominal.
      st_nxt.osc_word = PLR_OSC_NOMINAL; // [RULE_03]
      st_nxt.osc_cnt = '0; // [RULE_03]
      st_nxt.osc_clk = 1'b0; // [RULE_03]
      st_nxt.ref_cnt = '0;
      st_nxt.fb_cnt = '0;
      st_nxt.ref_per = '0;
      st_nxt.fb_per = '0;
      st_nxt.good_cnt = '0;
      st_nxt.locked = 1'b0; // [RULE_03]
      st_nxt.freq_ok = 1'b0;
      st_nxt.phase_ok = 1'b0;
      if (st_r.arst_cnt != 8'h00)
        st_nxt.arst_cnt = st_r.arst_cnt - 8'h01;
    end
    else
    begin
      // Oscillator: half period set by the control word.
      if (st_r.osc_cnt >= (st_r.osc_word - 16'h0001))
      begin
        st_nxt.osc_cnt = '0;
        st_nxt.osc_clk = ~st_r.osc_clk;
      end
      else
        st_nxt.osc_cnt = st_r.osc_cnt + 16'h0001;

      // Period counters restart from the first edges after release.
      if (st_r.ref_cnt != 16'hFFFF)
        st_nxt.ref_cnt = st_r.ref_cnt + 16'h0001; // [RULE_04]
      if (st_r.fb_cnt != 16'hFFFF)
        st_nxt.fb_cnt = st_r.fb_cnt + 16'h0001; // [RULE_04]
      if (ref_edge)
      begin
        st_nxt.ref_per = st_r.ref_cnt;
        st_nxt.ref_cnt = '0;
      end

      if (fb_edge)
      begin
        st_nxt.fb_per = st_r.fb_cnt;
        st_nxt.fb_cnt = '0;
        // Phase of feedback after reference, less the mode's lag.
        if (st_r.ref_cnt >= off)
          ph = st_r.ref_cnt - off;
        else
          ph = st_r.ref_per + st_r.ref_cnt - off;
        fdiff = (st_r.fb_cnt > st_r.ref_per) ? (st_r.fb_cnt - st_r.ref_per) :
          (st_r.ref_per - st_r.fb_cnt);
        f_ok = (fdiff <= PLR_PH_TOL) && (st_r.ref_per != 16'h0000);
        p_ok = (ph <= PLR_PH_TOL) || ((ph + PLR_PH_TOL) >= st_r.ref_per);
        st_nxt.freq_ok = f_ok;
        st_nxt.phase_ok = p_ok;

        // Detector output gated: with it off the word simply holds.
        if (pfd_enable_i) // [RULE_01]
        begin
          if (!f_ok)
          begin
            if ((st_r.fb_cnt > st_r.ref_per) && (st_r.osc_word > 16'h0001))
              st_nxt.osc_word = st_r.osc_word - 16'h0001;
            else if ((st_r.fb_cnt < st_r.ref_per) && (st_r.osc_word != 16'hFFFF))
              st_nxt.osc_word = st_r.osc_word + 16'h0001;
          end
          else if (!p_ok)
          begin
            if ((ph < (st_r.ref_per >> 1)) && (st_r.osc_word > 16'h0001))
              st_nxt.osc_word = st_r.osc_word - 16'h0001;
            else if (st_r.osc_word != 16'hFFFF)
              st_nxt.osc_word = st_r.osc_word + 16'h0001;
          end
        end

        // Lock needs a run of edges matching in phase and frequency.
        if (f_ok && p_ok)
        begin
          if (st_r.good_cnt != PLR_LOCK_GOOD)
            st_nxt.good_cnt = st_r.good_cnt + 4'h1;
          if ((st_r.good_cnt == (PLR_LOCK_GOOD - 4'h1)) && !st_r.locked)
          begin
            st_nxt.locked = 1'b1; // [RULE_09]
            ev[PLR_IRQ_LOCK_BIT] = 1'b1;
          end
        end
        else
        begin
          st_nxt.good_cnt = '0;
          if (st_r.locked)
          begin
            st_nxt.locked = 1'b0; // [RULE_09]
            ev[PLR_IRQ_UNLOCK_BIT] = 1'b1;
          end
        end
      end
      else if (st_r.locked && ((st_r.ref_cnt == 16'hFFFF) || (st_r.fb_cnt == 16'hFFFF)))
      begin
        // A stopped clock also ends lock.
        st_nxt.good_cnt = '0;
        st_nxt.locked = 1'b0; // [RULE_09]
        ev[PLR_IRQ_UNLOCK_BIT] = 1'b1;
      end

      // Optional self reset on loss of lock.
      if (ev[PLR_IRQ_UNLOCK_BIT] && st_r.auto_en)
      begin
        st_nxt.arst_cnt = PLR_AUTO_RST_CYC; // [RULE_06]
        ev[PLR_IRQ_AUTORST_BIT] = 1'b1; // [RULE_06]
      end
    end

    // External clock follows the oscillator, inverted in lvds mode; feedback port follows it only in zero delay and external feedback; both rest low in loop reset.
    st_nxt.ext_clk = (st_nxt.osc_clk ^ (st_r.mode == PLR_MODE_LVDS)) & ~loop_rst; // [RULE_16]
    st_nxt.fb_out = st_nxt.osc_clk & ext_path; // [RULE_13]

    // Sticky status: a new event wins over a clear in the same cycle.
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Synchronous reset to defined values.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
      st_r.mode <= PLR_MODE_RST;
      st_r.irq_en <= PLR_IRQ_EN_RST;
      st_r.osc_word <= PLR_OSC_NOMINAL;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output is a field of the state register.
  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign locked_o = st_r.locked;
  assign irq_o = st_r.irq;
  assign external_clock_output_o = st_r.ext_clk;
  assign feedback_out_port_o = st_r.fb_out;

endmodule

// >>> bench/plr_ctrl_checker.sv
// Port-level assertions for the loop lock and reset control block.
`timescale 1ns/10ps
module plr_ctrl_checker
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Core control.
  input wire logic loop_reset_i,
  input wire logic pfd_enable_i,
  input wire logic locked_o,
  input wire logic irq_o,
  // Clock pins.
  input wire logic ref_clk_i,
  input wire logic feedback_in_i,
  input wire logic external_clock_output_o,
  input wire logic feedback_out_port_o
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  // All checks run on the system clock and rest during reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ready_time;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready late");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_ready_cause;
    pready_o |-> $past(psel_i && penable_i);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_wr_zero;
    pready_o && pwrite_i |-> prdata_o == 32'h0000_0000;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
  property p_rst_lock;
    loop_reset_i [*3] |=> !locked_o;
  endproperty
  a_rst_lock: assert property (p_rst_lock) else $error("lock kept in reset");
  property p_rst_clk;
    loop_reset_i [*4] |=> !external_clock_output_o && !feedback_out_port_o;
  endproperty
  a_rst_clk: assert property (p_rst_clk) else $error("clock out in reset");
  property p_relock;
    $fell(loop_reset_i) && pfd_enable_i |-> ##[1:1000] locked_o;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock");
  // Main scenarios.
  c_err: cover property (pslverr_o);
  c_lock: cover property ($rose(locked_o));
  c_irq: cover property ($rose(irq_o));
endmodule

bind plr_ctrl plr_ctrl_checker plr_ctrl_checker_inst (.clk_i, .rst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .loop_reset_i,
  .pfd_enable_i, .locked_o, .irq_o, .ref_clk_i, .feedback_in_i, .external_clock_output_o,
  .feedback_out_port_o);

// >>> bench/plr_core_model.sv
// Core logic and board model that drive the reference, feedback and loop reset.
`timescale 1ns/10ps
module plr_core_model
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench commands.
  input wire logic [7:0] ref_half_i,
  input wire logic hold_i,
  input wire logic pulse_i,
  // Block outputs.
  input wire logic locked_i,
  input wire logic feedback_out_port_i,
  // Pins into the block.
  output logic ref_clk_o,
  output logic feedback_in_o,
  output logic loop_reset_o,
  output logic dom_rst_n_o
);
  logic [7:0] half_cnt;
  logic [2:0] pulse_cnt;
  // Reference toggles every ref_half_i cycles; a pulse request stretches to four cycles.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      half_cnt <= 8'h00;
      ref_clk_o <= 1'b0;
      pulse_cnt <= 3'h0;
    end
    else
    begin
      half_cnt <= (half_cnt + 8'h01 >= ref_half_i) ? 8'h00 : half_cnt + 8'h01;
      if (half_cnt + 8'h01 >= ref_half_i)
        ref_clk_o <= ~ref_clk_o;
      pulse_cnt <= pulse_i ? 3'h4 : ((pulse_cnt != 3'h0) ? pulse_cnt - 3'h1 : 3'h0);
    end
  end
  // Loop reset is held or pulsed by the core; the feedback is a board trace.
  assign loop_reset_o = hold_i || (pulse_cnt != 3'h0);
  // One single-ended standard on every loop pin; high bandwidth is never chosen.
  assign feedback_in_o = feedback_out_port_i;
  assign dom_rst_n_o = locked_i && !loop_reset_o;
endmodule

// >>> bench/tb.sv
// Self-checking bench for the loop lock and reset control block.
`timescale 1ns/10ps
module tb;
  import plr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic pfd_enable_i = 1'b0;
  logic [7:0] ref_half = 8'h08;
  logic hold = 1'b1;
  logic pulse = 1'b0;
  logic [31:0] prdata_o, rd, seen;
  logic pready_o, pslverr_o, locked_o, irq_o, ref_clk_i, feedback_in_i, loop_reset_i, er;
  logic external_clock_output_o, feedback_out_port_o, dom_rst_n;
  int mismatches = 0;
  int check_count = 0;
  int ctrl_m, en_m, k;

  always #20 clk_i = ~clk_i;

  plr_ctrl #(.SIDE_LOC(1'b1)) plr_ctrl_inst (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .loop_reset_i, .pfd_enable_i,
    .locked_o, .irq_o, .ref_clk_i, .feedback_in_i, .external_clock_output_o,
    .feedback_out_port_o);
  plr_core_model plr_core_model_inst (.clk_i, .rst_n_i, .ref_half_i(ref_half), .hold_i(hold),
    .pulse_i(pulse), .locked_i(locked_o), .feedback_out_port_i(feedback_out_port_o),
    .ref_clk_o(ref_clk_i), .feedback_in_o(feedback_in_i), .loop_reset_o(loop_reset_i),
    .dom_rst_n_o(dom_rst_n));

  // Compares one value with its expectation and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound and keeps data and error.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
      mismatches++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Waits a bounded time for the lock flag to reach a level.
  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (locked_o !== v && n < 1000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("locked", 32'(locked_o), 32'(v));
  endtask

  // Sees whether a pin toggles high within forty cycles.
  task automatic watch(input logic fb);
    seen = 32'h0;
    repeat (40)
    begin
      @(posedge clk_i);
      seen = seen | 32'(fb ? feedback_out_port_o : external_clock_output_o);
    end
  endtask

  // Cuts a hung run short.
  initial
  begin
    #(40 * 40000);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'h769F));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ctrl_m = 32'h20;
    apb(1'b0, PLR_REG_CTRL, 32'h0);
    chk("ctrl", rd, ctrl_m);
    apb(1'b0, PLR_REG_OSC_WORD, 32'h0);
    chk("osc", rd, 32'h8);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk("slverr", 32'(er), 32'h1);
    // Detector enabled by the core, then loop reset released on a running reference.
    pfd_enable_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    hold <= 1'b0;
    wait_lock(1'b1);
    chk("dom_rst_n", 32'(dom_rst_n), 32'h1);
    apb(1'b0, PLR_REG_STATUS, 32'h0);
    chk("status", rd, 32'h1D);
    // Interrupt raised, masked at random, enabled and cleared.
    en_m = $urandom & 32'hF;
    apb(1'b1, PLR_REG_IRQ_EN, en_m);
    apb(1'b0, PLR_REG_IRQ_EN, 32'h0);
    chk("irq_en", rd, en_m);
    chk("irq_o", 32'(irq_o), en_m & 32'h1);
    apb(1'b1, PLR_REG_IRQ_EN, 32'h1);
    @(posedge clk_i);
    chk("irq_o", 32'(irq_o), 32'h1);
    apb(1'b1, PLR_REG_IRQ_CLR, 32'hF);
    repeat (2) @(posedge clk_i);
    chk("irq_o", 32'(irq_o), 32'h0);
    // Every mode code, with refused codes and the feedback port per mode.
    for (k = 0; k < 8; k++)
    begin
      apb(1'b1, PLR_REG_CTRL, k << 4);
      if (k < 6)
        ctrl_m = k << 4;
      apb(1'b0, PLR_REG_CTRL, 32'h0);
      chk("ctrl", rd, ctrl_m);
      apb(1'b0, PLR_REG_IRQ_STAT, 32'h0);
      chk("mode_err", rd & 32'h8, (k > 5) ? 32'h8 : 32'h0);
      watch(1'b1);
      chk("feedback_out_port", seen, (k == 3 || k == 4) ? 32'h1 : 32'h0);
    end
    apb(1'b1, PLR_REG_IRQ_CLR, 32'hF);
    apb(1'b1, PLR_REG_CTRL, 32'h20);
    // Loop held in reset, then released to relock.
    hold <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("locked", 32'(locked_o), 32'h0);
    chk("external_clock_output", 32'(external_clock_output_o), 32'h0);
    apb(1'b0, PLR_REG_STATUS, 32'h0);
    chk("in_reset", rd & 32'h3, 32'h2);
    hold <= 1'b0;
    wait_lock(1'b1);
    apb(1'b1, PLR_REG_IRQ_CLR, 32'hF);
    // Detector off while the reference moves: word frozen, loop runs, self reset fires.
    apb(1'b1, PLR_REG_CTRL, 32'h21);
    pfd_enable_i <= 1'b0;
    ref_half <= 8'h0C;
    wait_lock(1'b0);
    repeat (100) @(posedge clk_i);
    apb(1'b0, PLR_REG_OSC_WORD, 32'h0);
    chk("osc", rd, 32'h8);
    watch(1'b0);
    chk("clk_runs", seen, 32'h1);
    apb(1'b0, PLR_REG_IRQ_STAT, 32'h0);
    chk("self_rst", rd & 32'h6, 32'h6);
    ref_half <= 8'h08;
    pfd_enable_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pulse <= 1'b1;
    @(posedge clk_i);
    pulse <= 1'b0;
    wait_lock(1'b1);
    tally_and_finish();
  end
endmodule
